// ===== core/tpg_pkg.sv
/*
 * Constants and carrier types of the serial link test-pattern generator.
 * Assumes one 100 MHz clock and a byte-wide register port at the printed offsets.
 */
package tpg_pkg;

    // Register offsets
    localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
    localparam logic [11:0] ADDR_USER_FIRST = 12'h551;
    localparam logic [11:0] ADDR_USER_LAST  = 12'h558;
    localparam logic [11:0] ADDR_TRANSPORT  = 12'h571;
    localparam logic [11:0] ADDR_SYNC_CTRL  = 12'h572;
    localparam logic [11:0] ADDR_IFACE_TEST = 12'h573;
    localparam logic [11:0] ADDR_LINK_TEST  = 12'h574;

    // Reset values
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam logic [7:0] SYNC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] SOFT_RESET_CMD   = 8'h81;

    // Field positions
    localparam int TRANSPORT_TEST_BIT = 5;
    localparam int SEL_MSB            = 3;
    localparam int SEL_LSB            = 0;
    localparam int INJ_MSB            = 5;
    localparam int INJ_LSB            = 4;
    localparam int LINK_SEL_MSB       = 2;
    localparam int LINK_SEL_LSB       = 0;

    // Pattern selector codes
    localparam logic [3:0] PAT_OFF      = 4'h0;
    localparam logic [3:0] PAT_CHECKER  = 4'h1;
    localparam logic [3:0] PAT_TOGGLE   = 4'h2;
    localparam logic [3:0] PAT_PRBS31   = 4'h3;
    localparam logic [3:0] PAT_PRBS23   = 4'h4;
    localparam logic [3:0] PAT_PRBS15   = 4'h5;
    localparam logic [3:0] PAT_PRBS9    = 4'h6;
    localparam logic [3:0] PAT_PRBS7    = 4'h7;
    localparam logic [3:0] PAT_RAMP     = 4'h8;
    localparam logic [3:0] PAT_USER_REP = 4'hE;
    localparam logic [3:0] PAT_USER_ONE = 4'hF;

    // Injection point codes
    localparam logic [1:0] INJ_SAMPLE   = 2'h0;
    localparam logic [1:0] INJ_SYMBOL   = 2'h1;
    localparam logic [1:0] INJ_OCTET    = 2'h2;

    // Fixed pattern words, left aligned in 16 bits
    localparam logic [15:0] CHECKER_WORD = 16'h5555;
    localparam logic [15:0] ONES_WORD    = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;

    // Ramp step per injection width, left aligned
    localparam logic [15:0] RAMP_STEP_SAMPLE = 16'h0001;
    localparam logic [15:0] RAMP_STEP_SYMBOL = 16'h0040;
    localparam logic [15:0] RAMP_STEP_OCTET  = 16'h0100;

    // Bits consumed per pattern word
    localparam logic [4:0] BITS_SAMPLE = 5'h10;
    localparam logic [4:0] BITS_SYMBOL = 5'h0A;
    localparam logic [4:0] BITS_OCTET  = 5'h08;

    // PRBS generators: order, second tap, seed
    localparam int NUM_PRBS = 5;
    localparam int PRBS_ORDER [NUM_PRBS] = '{31, 23, 15, 9, 7};
    localparam int PRBS_TAP   [NUM_PRBS] = '{28, 18, 14, 5, 6};
    localparam logic [30:0] PRBS_SEED [NUM_PRBS] =
        '{31'h0003AFFF, 31'h003AFF, 31'h03AF, 31'h092, 31'h07};

    localparam int NUM_USER_WORDS = 4;
    localparam logic [2:0] USER_DONE = 3'h4;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage

// ===== core/prbs_gen.sv
/*
 * Fibonacci PRBS source that yields up to 16 bits per step, first bit at bit 15.
 * Assumes the caller holds i_bits at 16, 10 or 8 and steps at most once a cycle.
 */
module prbs_gen #(
    parameter int          ORDER = 7,
    parameter int          TAP   = 6,
    parameter logic [30:0] SEED  = 31'h07
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_load,
    input  wire logic        i_step,
    input  wire logic [4:0]  i_bits,
    output logic      [15:0] o_word
);

    logic [ORDER-1:0] state;
    logic [ORDER-1:0] next_state;

    always_comb
    begin
        logic [ORDER-1:0] walk;
        logic             fb;
        walk       = state;
        fb         = 1'b0;
        next_state = state;
        o_word     = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            fb            = walk[ORDER-1] ^ walk[TAP-1];
            o_word[15-i]  = walk[ORDER-1];
            walk          = {walk[ORDER-2:0], fb};
            if (5'(i + 1) == i_bits)
                next_state = walk;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            state <= SEED[ORDER-1:0];
        else if (i_load)
            state <= SEED[ORDER-1:0];
        else if (i_step)
            state <= next_state;
    end

endmodule // prbs_gen

// ===== core/serial_link_test_pattern_gen.sv
/*
 * Transmit-path test-pattern generator with its byte-wide configuration registers.
 * Assumes all stream inputs and the register port are synchronous to i_clk and
 * that the sample stream carries one converter, two samples per frame.
 */
// Summary of operation
// R1 - Interface patterns set in 0x573, link layer patterns set in 0x574.
// R2 - Leaving test mode needs soft reset 0x81 to 0x00; command self-clears.
// R3 - Bit 5 of 0x571 enables transport sample test using raw samples.
// R4 - Low four bits of 0x573 select pattern; 0000 is off by default.
// R5 - Bits 5:4 of 0x573 pick the injection point.
// R6 - Code 00 injects 16-bit words at samples; both frame samples equal.
// R7 - Code 01 injects 10-bit words at physical symbols, one per symbol.
// R8 - Code 10 injects 8-bit words at scrambler input, one per octet.
// R9 - Checkerboard alternates 0101/1010; toggle alternates zeros and ones, width-sized.
// R10 - Codes 0011 and 0100 give 31-bit and 23-bit PRBS with given seeds.
// R11 - Codes 0101, 0110, 0111 give 15, 9, 7-bit PRBS with given seeds.
// R12 - Code 1000 ramps by one per word, wrapping at injection width.
// R13 - Code 1110 repeats the four user words continuously.
// R14 - Code 1111 sends the four user words once, then zeros.
// R15 - User words use bits 15:0, 15:6 or 15:9 by injection point.
// R16 - Low three bits of 0x574 select the link layer test pattern.
// R17 - Software disables sync request by writing 0xC0 to 0x572 during link tests.
// R18 - With no test selected, converter data passes through unchanged.
module serial_link_test_pattern_gen (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire tpg_pkg::reg_req_t i_reg_req,
    output logic      [7:0]        o_reg_rdata,
    output logic                   o_reg_rvalid,
    input  wire logic [15:0]       i_sample_data,
    input  wire logic              i_sample_valid,
    output logic      [15:0]       o_sample_data,
    output logic                   o_sample_valid,
    input  wire logic [9:0]        i_symbol_data,
    input  wire logic              i_symbol_valid,
    output logic      [9:0]        o_symbol_data,
    output logic                   o_symbol_valid,
    input  wire logic [7:0]        i_octet_data,
    input  wire logic              i_octet_valid,
    output logic      [7:0]        o_octet_data,
    output logic                   o_octet_valid,
    output logic                   o_soft_reset,
    output logic                   o_transport_test_en,
    output logic      [2:0]        o_link_test_sel,
    output logic      [7:0]        o_link_sync_ctrl
);

    logic [7:0]  transport_sample_test_ctrl;
    logic [7:0]  link_sync_ctrl;
    logic [7:0]  interface_test_select;
    logic [7:0]  link_layer_test_select;
    logic [7:0]  user_byte [8];
    logic [7:0]  active_select;
    logic        soft_reset_cmd;
    logic        cfg_write;
    logic        gen_load;
    logic [3:0]  pat_sel;
    logic [1:0]  inj_point;
    logic        sample_phase;
    logic        advance;
    logic [4:0]  step_bits;
    logic [15:0] ramp_step;
    logic [15:0] ramp;
    logic        toggle_phase;
    logic [2:0]  user_index;
    logic [15:0] user_word;
    logic [15:0] pattern;
    logic [15:0] prbs_word [tpg_pkg::NUM_PRBS];

    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] target);
        addr_hit = (addr == target);
    endfunction

    function automatic logic is_user_addr(input logic [11:0] addr);
        is_user_addr = (addr >= tpg_pkg::ADDR_USER_FIRST) && (addr <= tpg_pkg::ADDR_USER_LAST);
    endfunction

    assign cfg_write      = i_reg_req.wr;
    assign soft_reset_cmd = cfg_write && addr_hit(i_reg_req.addr, tpg_pkg::ADDR_SOFT_RESET)
                            && (i_reg_req.wdata == tpg_pkg::SOFT_RESET_CMD);

    // Soft reset is a one-cycle pulse, so the command reads back as cleared
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_soft_reset <= 1'b0;
        else
            o_soft_reset <= soft_reset_cmd; // see R2
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            transport_sample_test_ctrl <= tpg_pkg::RESET_BYTE;
            link_sync_ctrl             <= tpg_pkg::SYNC_CTRL_RESET;
            interface_test_select      <= tpg_pkg::RESET_BYTE;
            link_layer_test_select     <= tpg_pkg::RESET_BYTE;
        end
        else if (soft_reset_cmd)
        begin
            transport_sample_test_ctrl <= tpg_pkg::RESET_BYTE; // see R2
            link_sync_ctrl             <= tpg_pkg::SYNC_CTRL_RESET;
            interface_test_select      <= tpg_pkg::RESET_BYTE;
            link_layer_test_select     <= tpg_pkg::RESET_BYTE;
        end
        else if (cfg_write)
        begin
            if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_TRANSPORT))
                transport_sample_test_ctrl <= i_reg_req.wdata; // see R3
            if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_SYNC_CTRL))
                link_sync_ctrl <= i_reg_req.wdata; // see R17
            if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_IFACE_TEST))
                interface_test_select <= i_reg_req.wdata; // see R1
            if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_LINK_TEST))
                link_layer_test_select <= i_reg_req.wdata; // see R1
        end
    end

    generate
        for (genvar u = 0; u < 8; u++)
        begin : g_user
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    user_byte[u] <= tpg_pkg::RESET_BYTE;
                else if (soft_reset_cmd)
                    user_byte[u] <= tpg_pkg::RESET_BYTE;
                else if (cfg_write && addr_hit(i_reg_req.addr, 12'(tpg_pkg::ADDR_USER_FIRST + 12'(u))))
                    user_byte[u] <= i_reg_req.wdata;
            end
        end
    endgenerate

    // A write of zero to the selector does not stop the patterns; the last
    // nonzero selection stays in force until the soft reset clears it.
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            active_select <= tpg_pkg::RESET_BYTE;
        else if (soft_reset_cmd)
            active_select <= tpg_pkg::RESET_BYTE; // see R2
        else if (cfg_write && addr_hit(i_reg_req.addr, tpg_pkg::ADDR_IFACE_TEST)
                 && (i_reg_req.wdata[tpg_pkg::SEL_MSB:tpg_pkg::SEL_LSB] != tpg_pkg::PAT_OFF))
            active_select <= i_reg_req.wdata; // see R2
    end

    assign pat_sel   = active_select[tpg_pkg::SEL_MSB:tpg_pkg::SEL_LSB]; // see R4
    assign inj_point = active_select[tpg_pkg::INJ_MSB:tpg_pkg::INJ_LSB]; // see R5
    assign gen_load  = soft_reset_cmd
                       || (cfg_write && addr_hit(i_reg_req.addr, tpg_pkg::ADDR_IFACE_TEST));

    // Register read port: data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata  <= tpg_pkg::RESET_BYTE;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_req.rd;
            if (!i_reg_req.rd)
                o_reg_rdata <= tpg_pkg::RESET_BYTE;
            else if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_TRANSPORT))
                o_reg_rdata <= transport_sample_test_ctrl;
            else if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_SYNC_CTRL))
                o_reg_rdata <= link_sync_ctrl;
            else if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_IFACE_TEST))
                o_reg_rdata <= interface_test_select;
            else if (addr_hit(i_reg_req.addr, tpg_pkg::ADDR_LINK_TEST))
                o_reg_rdata <= link_layer_test_select;
            else if (is_user_addr(i_reg_req.addr))
                o_reg_rdata <= user_byte[3'(i_reg_req.addr - tpg_pkg::ADDR_USER_FIRST)];
            else
                o_reg_rdata <= tpg_pkg::RESET_BYTE; // see R2
        end
    end

    // Sample stream: two samples per frame, pattern advances on the second one
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            sample_phase <= 1'b0;
        else if (gen_load)
            sample_phase <= 1'b0;
        else if (i_sample_valid)
            sample_phase <= ~sample_phase; // see R6
    end

    always_comb
    begin
        case (inj_point)
            tpg_pkg::INJ_SAMPLE:
            begin
                advance   = i_sample_valid && sample_phase; // see R6
                step_bits = tpg_pkg::BITS_SAMPLE;
                ramp_step = tpg_pkg::RAMP_STEP_SAMPLE;
            end
            tpg_pkg::INJ_SYMBOL:
            begin
                advance   = i_symbol_valid; // see R7
                step_bits = tpg_pkg::BITS_SYMBOL;
                ramp_step = tpg_pkg::RAMP_STEP_SYMBOL;
            end
            tpg_pkg::INJ_OCTET:
            begin
                advance   = i_octet_valid; // see R8
                step_bits = tpg_pkg::BITS_OCTET;
                ramp_step = tpg_pkg::RAMP_STEP_OCTET;
            end
            default:
            begin
                advance   = 1'b0;
                step_bits = tpg_pkg::BITS_SAMPLE;
                ramp_step = tpg_pkg::RAMP_STEP_SAMPLE;
            end
        endcase
    end

    generate
        for (genvar p = 0; p < tpg_pkg::NUM_PRBS; p++)
        begin : g_prbs
            prbs_gen #(
                .ORDER (tpg_pkg::PRBS_ORDER[p]),
                .TAP   (tpg_pkg::PRBS_TAP[p]),
                .SEED  (tpg_pkg::PRBS_SEED[p])
            ) u_prbs (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_load (gen_load),
                .i_step (advance),
                .i_bits (step_bits),
                .o_word (prbs_word[p])
            ); // see R10
        end
    endgenerate

    // Words are kept left aligned so one ramp and one toggle serve every width
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ramp         <= tpg_pkg::ZERO_WORD;
            toggle_phase <= 1'b0;
        end
        else if (gen_load)
        begin
            ramp         <= tpg_pkg::ZERO_WORD;
            toggle_phase <= 1'b0;
        end
        else if (advance)
        begin
            ramp         <= ramp + ramp_step; // see R12
            toggle_phase <= ~toggle_phase; // see R9
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            user_index <= 3'h0;
        else if (gen_load)
            user_index <= 3'h0;
        else if (advance)
        begin
            if (pat_sel == tpg_pkg::PAT_USER_ONE)
            begin
                if (user_index != tpg_pkg::USER_DONE)
                    user_index <= user_index + 3'h1; // see R14
            end
            else
                user_index <= {1'b0, 2'(user_index[1:0] + 2'h1)}; // see R13
        end
    end

    always_comb
    begin
        if (user_index == tpg_pkg::USER_DONE)
            user_word = tpg_pkg::ZERO_WORD; // see R14
        else
            user_word = {user_byte[{user_index[1:0], 1'b0}], user_byte[{user_index[1:0], 1'b1}]};
    end

    always_comb
    begin
        case (pat_sel)
            tpg_pkg::PAT_CHECKER:  pattern = toggle_phase ? ~tpg_pkg::CHECKER_WORD : tpg_pkg::CHECKER_WORD; // see R9
            tpg_pkg::PAT_TOGGLE:   pattern = toggle_phase ? tpg_pkg::ONES_WORD : tpg_pkg::ZERO_WORD; // see R9
            tpg_pkg::PAT_PRBS31:   pattern = prbs_word[0]; // see R10
            tpg_pkg::PAT_PRBS23:   pattern = prbs_word[1]; // see R10
            tpg_pkg::PAT_PRBS15:   pattern = prbs_word[2]; // see R11
            tpg_pkg::PAT_PRBS9:    pattern = prbs_word[3]; // see R11
            tpg_pkg::PAT_PRBS7:    pattern = prbs_word[4]; // see R11
            tpg_pkg::PAT_RAMP:     pattern = ramp; // see R12
            tpg_pkg::PAT_USER_REP: pattern = user_word; // see R13
            tpg_pkg::PAT_USER_ONE: pattern = user_word; // see R14
            default:               pattern = tpg_pkg::ZERO_WORD;
        endcase
    end

    // Output stage: one cycle of latency on every path, valid follows the input
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_sample_data  <= tpg_pkg::ZERO_WORD;
            o_sample_valid <= 1'b0;
        end
        else
        begin
            o_sample_valid <= i_sample_valid;
            if (pat_sel != tpg_pkg::PAT_OFF && inj_point == tpg_pkg::INJ_SAMPLE)
                o_sample_data <= pattern; // see R6
            else
                o_sample_data <= i_sample_data; // see R18
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_symbol_data  <= 10'h000;
            o_symbol_valid <= 1'b0;
        end
        else
        begin
            o_symbol_valid <= i_symbol_valid;
            if (pat_sel != tpg_pkg::PAT_OFF && inj_point == tpg_pkg::INJ_SYMBOL)
                o_symbol_data <= pattern[15:6]; // see R7
            else
                o_symbol_data <= i_symbol_data; // see R18
        end
    end

    // The user word offers only seven bits here, placed low with a zero on top
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_octet_data  <= 8'h00;
            o_octet_valid <= 1'b0;
        end
        else
        begin
            o_octet_valid <= i_octet_valid;
            if (pat_sel == tpg_pkg::PAT_OFF || inj_point != tpg_pkg::INJ_OCTET)
                o_octet_data <= i_octet_data; // see R18
            else if (pat_sel == tpg_pkg::PAT_USER_REP || pat_sel == tpg_pkg::PAT_USER_ONE)
                o_octet_data <= {1'b0, pattern[15:9]}; // see R15
            else
                o_octet_data <= pattern[15:8]; // see R8
        end
    end

    // Controls for the transport and link layers, which do the actual substitution
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_transport_test_en <= 1'b0;
            o_link_test_sel     <= 3'h0;
            o_link_sync_ctrl    <= tpg_pkg::SYNC_CTRL_RESET;
        end
        else
        begin
            o_transport_test_en <= transport_sample_test_ctrl[tpg_pkg::TRANSPORT_TEST_BIT]; // see R3
            o_link_test_sel     <= link_layer_test_select[tpg_pkg::LINK_SEL_MSB:tpg_pkg::LINK_SEL_LSB]; // see R16
            o_link_sync_ctrl    <= link_sync_ctrl; // see R17
        end
    end

endmodule // serial_link_test_pattern_gen

// ===== tb/tpg_sva.sv
/*
 * Port checker for the serial link test-pattern generator.
 * Assumes it is bound onto the generator and sees only its ports.
 */
module tpg_sva (
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire tpg_pkg::reg_req_t i_reg_req,
    input wire logic [7:0]        o_reg_rdata,
    input wire logic              o_reg_rvalid,
    input wire logic              i_sample_valid,
    input wire logic              o_sample_valid,
    input wire logic              i_symbol_valid,
    input wire logic              o_symbol_valid,
    input wire logic              i_octet_valid,
    input wire logic              o_octet_valid,
    input wire logic              o_soft_reset,
    input wire logic              o_transport_test_en,
    input wire logic [2:0]        o_link_test_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    chk_read_answer: assert property (i_reg_req.rd |=> o_reg_rvalid)
        else $error("read answer missing");
    chk_read_quiet: assert property (!i_reg_req.rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
        else $error("read answer without request");
    chk_soft_pulse: assert property ((i_reg_req.wr && i_reg_req.addr == 12'h000 && i_reg_req.wdata == 8'h81)
        |=> o_soft_reset ##1 !o_soft_reset)
        else $error("soft reset pulse wrong");
    chk_soft_cause: assert property (o_soft_reset |-> $past(i_reg_req.wr) && $past(i_reg_req.addr) == 12'h000)
        else $error("soft reset without command");
    chk_sample_lat: assert property (o_sample_valid == $past(i_sample_valid))
        else $error("sample latency wrong");
    chk_symbol_lat: assert property (o_symbol_valid == $past(i_symbol_valid))
        else $error("symbol latency wrong");
    chk_octet_lat: assert property (o_octet_valid == $past(i_octet_valid))
        else $error("octet latency wrong");
    chk_transport_bit: assert property ((i_reg_req.wr && i_reg_req.addr == 12'h571)
        |=> ##1 o_transport_test_en == $past(i_reg_req.wdata[5], 2))
        else $error("transport enable not taken");
    chk_link_select: assert property ((i_reg_req.wr && i_reg_req.addr == 12'h574)
        |=> ##1 o_link_test_sel == $past(i_reg_req.wdata[2:0], 2))
        else $error("link select not taken");
endmodule // tpg_sva

bind serial_link_test_pattern_gen tpg_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_req(i_reg_req),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_sample_valid(i_sample_valid),
    .o_sample_valid(o_sample_valid), .i_symbol_valid(i_symbol_valid), .o_symbol_valid(o_symbol_valid),
    .i_octet_valid(i_octet_valid), .o_octet_valid(o_octet_valid), .o_soft_reset(o_soft_reset),
    .o_transport_test_en(o_transport_test_en), .o_link_test_sel(o_link_test_sel));

// ===== tb/link_rx_model.sv
/*
 * Receiver side model: captures every output word of the generator.
 * Assumes only one stream or read answer is valid in any cycle.
 */
module link_rx_model (
    input  wire logic        i_clk,
    input  wire logic        i_smp_v,
    input  wire logic [15:0] i_smp_d,
    input  wire logic        i_sym_v,
    input  wire logic [9:0]  i_sym_d,
    input  wire logic        i_oct_v,
    input  wire logic [7:0]  i_oct_d,
    input  wire logic        i_rd_v,
    input  wire logic [7:0]  i_rd_d,
    output logic             o_stb,
    output logic      [17:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sampled mid-cycle so the word is settled; no back-pressure exists
    always_ff @(negedge i_clk)
    begin
        o_stb  <= i_smp_v | i_sym_v | i_oct_v | i_rd_v;
        o_word <= i_smp_v ? {2'h0, i_smp_d} : i_sym_v ? {2'h1, 6'h00, i_sym_d} :
                  i_oct_v ? {2'h2, 8'h00, i_oct_d} : {2'h3, 8'h00, i_rd_d};
    end
endmodule // link_rx_model

// ===== tb/tb_serial_link_test_pattern_gen.sv
/*
 * Self-checking bench for the serial link test-pattern generator.
 * Assumes the receiver model and the bound port checker.
 */
module tb_serial_link_test_pattern_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    tpg_pkg::reg_req_t req = '0;
    logic              smp_v = 1'b0, sym_v = 1'b0, oct_v = 1'b0;
    logic [15:0]       smp_d = '0, osd, d;
    logic [9:0]        sym_d = '0;
    logic [7:0]        oct_d = '0, rdata, lsync;
    logic [9:0]        oyd;
    logic [7:0]        ood;
    logic              rvalid, osv, oyv, oov, srst, tten, stb;
    logic [2:0]        lsel;
    logic [17:0]       word;
    logic [17:0]       exp_q[$];
    logic [15:0]       up[4];
    logic [7:0]        cfg[9] = '{8'h01, 8'h12, 8'h28, 8'h2E, 8'h1F, 8'h0F, 8'h18, 8'h0E, 8'h06};
    int                cnt[9] = '{8, 6, 260, 9, 7, 10, 1030, 10, 8};
    logic [15:0]       pn9[4] = '{16'h496F, 16'hC9A9, 16'h980C, 16'h651A};
    int                mismatches = 0;
    int                samples_checked = 0;

    serial_link_test_pattern_gen dut (.i_clk(clk), .i_rstn(rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_sample_data(smp_d), .i_sample_valid(smp_v), .o_sample_data(osd),
        .o_sample_valid(osv), .i_symbol_data(sym_d), .i_symbol_valid(sym_v), .o_symbol_data(oyd),
        .o_symbol_valid(oyv), .i_octet_data(oct_d), .i_octet_valid(oct_v), .o_octet_data(ood),
        .o_octet_valid(oov), .o_soft_reset(srst), .o_transport_test_en(tten), .o_link_test_sel(lsel),
        .o_link_sync_ctrl(lsync));
    link_rx_model rx (.i_clk(clk), .i_smp_v(osv), .i_smp_d(osd), .i_sym_v(oyv), .i_sym_d(oyd),
        .i_oct_v(oov), .i_oct_d(ood), .i_rd_v(rvalid), .i_rd_d(rdata), .o_stb(stb), .o_word(word));

    always #5 clk = ~clk;

    task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic reg_op(logic w, logic [11:0] a, logic [7:0] v);
        @(negedge clk);
        req = '{wr: w, rd: !w, addr: a, wdata: v};
        if (!w)
            exp_q.push_back({10'h300, v});
        @(negedge clk);
        req = '0;
    endtask

    // Valid is held high between calls so bursts run back to back
    task automatic send(logic [1:0] k, logic [15:0] e);
        @(negedge clk);
        d = 16'($urandom);
        {smp_v, sym_v, oct_v} = {k == 2'h0, k == 2'h1, k == 2'h2};
        {smp_d, sym_d, oct_d} = {d, d[9:0], d[7:0]};
        exp_q.push_back({k, e});
    endtask

    function automatic logic [15:0] pat(logic [3:0] s, logic [1:0] k, int i);
        logic [15:0] w;
        case (s)
            4'h1: w = i[0] ? 16'hAAAA : 16'h5555;
            4'h2: w = i[0] ? 16'hFFFF : 16'h0000;
            4'h6: w = pn9[i];
            4'h8: w = 16'(i) << (k == 2'h0 ? 0 : k == 2'h1 ? 6 : 8);
            4'hE: w = up[i % 4];
            default: w = i < 4 ? up[i] : 16'h0000;
        endcase
        if (k == 2'h1)
            return {6'h00, w[15:6]};
        if (k == 2'h2)
            return s[3:2] == 2'b11 ? {9'h000, w[15:9]} : {8'h00, w[15:8]};
        return w;
    endfunction

    // Pass-through cannot be predicted at send time, so the mask is applied here
    task automatic pass_burst();
        for (int i = 0; i < 6; i++)
        begin
            send(2'(i % 3), 16'h0000);
            exp_q[$][15:0] = i % 3 == 0 ? d : i % 3 == 1 ? {6'h00, d[9:0]} : {8'h00, d[7:0]};
        end
        @(negedge clk);
        {smp_v, sym_v, oct_v} = 3'b000;
    endtask

    always @(posedge clk)
    begin
        if (stb === 1'b1)
            check("output word", word, exp_q.size() ? exp_q.pop_front() : 18'h3FFFF);
    end

    initial
    begin
        void'($urandom(32'hc0f1629d));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int a = 12'h571; a <= 12'h574; a++)
            reg_op(1'b0, 12'(a), 8'h00);
        pass_burst();
        reg_op(1'b1, 12'h571, 8'h20);
        reg_op(1'b1, 12'h574, 8'h05);
        reg_op(1'b1, 12'h572, 8'hC0);
        reg_op(1'b0, 12'h574, 8'h05);
        check("transport enable", {17'h0, tten}, 18'h1);
        check("link select", {10'h0, lsync, lsel}, {10'h0, 8'hC0, 3'h5});
        reg_op(1'b0, 12'h123, 8'h00);
        reg_op(1'b0, 12'h000, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            d[7:0] = 8'($urandom);
            up[k / 2][(k % 2 ? 0 : 8) +: 8] = d[7:0];
            reg_op(1'b1, 12'h551 + 12'(k), d[7:0]);
        end
        for (int j = 0; j < 9; j++)
        begin
            reg_op(1'b1, 12'h573, cfg[j]);
            reg_op(1'b0, 12'h573, cfg[j]);
            for (int i = 0; i < cnt[j]; i++)
                send(cfg[j][5:4], pat(cfg[j][3:0], cfg[j][5:4], cfg[j][5:4] == 2'h0 ? i / 2 : i));
            @(negedge clk);
            {smp_v, sym_v, oct_v} = 3'b000;
        end
        for (int s = 3; s <= 7; s++)
        begin
            reg_op(1'b1, 12'h573, 8'(8'h20 + s));
            reg_op(1'b0, 12'h573, 8'(8'h20 + s));
        end
        reg_op(1'b1, 12'h000, 8'h81);
        check("soft reset", {17'h0, srst}, 18'h1);
        for (int a = 12'h571; a <= 12'h574; a++)
            reg_op(1'b0, 12'(a), 8'h00);
        pass_burst();
        repeat (4) @(negedge clk);
        check("queue drained", 18'(exp_q.size()), 18'h0);
        final_report();
    end

    initial
    begin
        #200us;
        mismatches++;
        final_report();
    end
endmodule // tb_serial_link_test_pattern_gen
